/* rtl/exec_core_regs.vh */
`ifndef EXEC_CORE_REGS_VH
`define EXEC_CORE_REGS_VH

// ==========================================================
// apb register byte offsets
`define ADDR_INSTR      12'h000
`define ADDR_WREG       12'h004
`define ADDR_BANK_SEL   12'h008
`define ADDR_CTRL       12'h00C
`define ADDR_STATUS     12'h010
`define ADDR_PROD       12'h014
`define ADDR_FSR2       12'h018
`define ADDR_MEM_ADDR   12'h01C
`define ADDR_MEM_DATA   12'h020
`define ADDR_STACK      12'h024
`define ADDR_EXEC_STAT  12'h028

// ==========================================================
// field positions
`define CTRL_EXT_BIT    0
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_Z          2
`define FLAG_OV         3
`define FLAG_N          4
`define ES_BUSY         0
`define ES_UNSUP        1
`define ES_UNDER        2
`define ES_OVER         3
`define ES_PTR_LSB      8
`define ES_PTR_MSB      12

// ==========================================================
// opcode fields and encodings
`define OP_MUL_LIT_HI   8'h0D
`define OP_MUL_FILE_HI  7'h01
`define OP_NEG_FILE_HI  7'h36
`define OP_POP          16'h0006
`define OP_IDLE         16'h0000
`define OP_IDLE_NIB     4'hF

// ==========================================================
// addressing constants
`define IDX_LIMIT       8'h5F
`define ACC_SFR_PAGE    4'hF
`define ACC_LOW_PAGE    4'h0

// ==========================================================
// sizes and reset values
`define DMEM_AW         12
`define STK_AW          5
`define STK_DW          21
`define STK_FULL        5'h1F
`define STK_EMPTY       5'h00
`define STK_ONE         5'h01
`define RST_BYTE        8'h00
`define RST_BANK        4'h0
`define RST_WORD        16'h0000
`define RST_ADDR        12'h000
`define RST_DATA        32'h00000000
`define RST_FLAGS       5'h00

`endif

/* rtl/store_ram.v */
`default_nettype none

// ==========================================================
// single-port memory, registered read data
module store_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // store_ram

`default_nettype wire

/* rtl/multiply_negate_pop_exec.v */
`include "exec_core_regs.vh"
`default_nettype none

module multiply_negate_pop_exec (
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR
);

  // ==========================================================
  // instruction cycle states
  localparam S_IDLE = 3'b000;
  localparam S_Q1   = 3'b001;
  localparam S_Q2   = 3'b010;
  localparam S_Q3   = 3'b011;
  localparam S_Q4   = 3'b100;

  reg  [2:0]              state_q;
  reg  [15:0]             instr_q;
  reg  [7:0]              wreg_q;
  reg  [3:0]              bsr_q;
  reg                     ext_q;
  reg  [4:0]              flags_q;
  reg  [7:0]              prod_hi_q;
  reg  [7:0]              prod_lo_q;
  reg  [11:0]             fsr2_q;
  reg  [11:0]             mem_addr_q;
  reg  [11:0]             faddr_q;
  reg  [`STK_AW-1:0]      ptr_q;
  reg                     unsup_q;
  reg                     under_q;
  reg                     over_q;
  reg                     is_mull_q;
  reg                     is_mulf_q;
  reg                     is_neg_q;
  reg                     is_pop_q;
  reg  [15:0]             prod_calc_q;
  reg  [7:0]              neg_calc_q;
  reg  [4:0]              neg_flags_q;
  reg                     busy_q;

  wire                    busy;
  wire                    apb_go;
  wire                    apb_wr;
  wire [7:0]              dmem_rdata;
  wire [`STK_DW-1:0]      stk_rdata;
  wire [7:0]              fbyte;
  wire [7:0]              lit;
  wire                    abit;
  reg  [11:0]             faddr_d;
  reg  [11:0]             dmem_addr;
  reg                     dmem_we;
  reg  [7:0]              dmem_wdata;
  reg                     stk_we;
  reg  [`STK_AW-1:0]      stk_addr;
  reg  [31:0]             rdata_d;
  reg                     err_d;
  wire                    d_mull;
  wire                    d_mulf;
  wire                    d_neg;
  wire                    d_pop;
  wire                    d_idle;

  assign busy   = (state_q != S_IDLE);
  assign apb_go = PSEL & PENABLE & PREADY;
  assign apb_wr = apb_go & PWRITE;
  assign fbyte  = instr_q[7:0];
  assign lit    = instr_q[7:0];
  assign abit   = instr_q[8];

  // ==========================================================
  // decode
  assign d_mull = (instr_q[15:8] == `OP_MUL_LIT_HI);
  assign d_mulf = (instr_q[15:9] == `OP_MUL_FILE_HI);
  assign d_neg  = (instr_q[15:9] == `OP_NEG_FILE_HI);
  assign d_pop  = (instr_q == `OP_POP);
  assign d_idle = (instr_q == `OP_IDLE) || (instr_q[15:12] == `OP_IDLE_NIB);

  // ==========================================================
  // file address generation
  always @* begin
    if (abit) begin
      faddr_d = {bsr_q, fbyte};
    end else if (ext_q && (fbyte <= `IDX_LIMIT)) begin
      faddr_d = fsr2_q + {4'h0, fbyte};
    end else if (fbyte <= `IDX_LIMIT) begin
      faddr_d = {`ACC_LOW_PAGE, fbyte};
    end else begin
      faddr_d = {`ACC_SFR_PAGE, fbyte};
    end
  end

  // ==========================================================
  // memory port steering
  always @* begin
    dmem_we    = 1'b0;
    dmem_wdata = apb_wr ? PWDATA[7:0] : `RST_BYTE;
    dmem_addr  = mem_addr_q;
    stk_we     = 1'b0;
    stk_addr   = ptr_q - `STK_ONE;
    if (busy) begin
      dmem_addr = faddr_q;
      if ((state_q == S_Q4) && is_neg_q) begin
        dmem_we    = 1'b1;
        dmem_wdata = neg_calc_q;
      end
    end else if (apb_wr && (PADDR == `ADDR_MEM_DATA)) begin
      dmem_we = 1'b1;
    end else if (apb_wr && (PADDR == `ADDR_STACK) && (ptr_q != `STK_FULL)) begin
      stk_we   = 1'b1;
      stk_addr = ptr_q;
    end
  end

  store_ram #(.AW(`DMEM_AW), .DW(8)) u_dmem (
    .clk   (CLK),
    .we    (dmem_we),
    .addr  (dmem_addr),
    .wdata (dmem_wdata),
    .rdata (dmem_rdata)
  );

  store_ram #(.AW(`STK_AW), .DW(`STK_DW)) u_stack (
    .clk   (CLK),
    .we    (stk_we),
    .addr  (stk_addr),
    .wdata (PWDATA[`STK_DW-1:0]),
    .rdata (stk_rdata)
  );

  // ==========================================================
  // instruction cycle sequencer
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q     <= S_IDLE;
      faddr_q     <= `RST_ADDR;
      is_mull_q   <= 1'b0;
      is_mulf_q   <= 1'b0;
      is_neg_q    <= 1'b0;
      is_pop_q    <= 1'b0;
      prod_calc_q <= `RST_WORD;
      neg_calc_q  <= `RST_BYTE;
      neg_flags_q <= `RST_FLAGS;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (apb_wr && (PADDR == `ADDR_INSTR)) begin
            state_q <= S_Q1;
          end
        end
        S_Q1: begin
          faddr_q   <= faddr_d;
          is_mull_q <= d_mull & ~d_idle;
          is_mulf_q <= d_mulf & ~d_idle;
          is_neg_q  <= d_neg & ~d_idle;
          is_pop_q  <= d_pop & ~d_idle;
          state_q   <= S_Q2;
        end
        S_Q2: begin
          state_q <= S_Q3;
        end
        S_Q3: begin
          if (is_mull_q) begin
            prod_calc_q <= {8'h00, wreg_q} * {8'h00, lit};
          end else begin
            prod_calc_q <= {8'h00, wreg_q} * {8'h00, dmem_rdata};
          end
          neg_calc_q              <= (~dmem_rdata) + 8'h01;
          neg_flags_q[`FLAG_C]    <= (dmem_rdata == 8'h00);
          neg_flags_q[`FLAG_DC]   <= (dmem_rdata[3:0] == 4'h0);
          neg_flags_q[`FLAG_Z]    <= (dmem_rdata == 8'h00);
          neg_flags_q[`FLAG_OV]   <= (dmem_rdata == 8'h80);
          neg_flags_q[`FLAG_N]    <= (((~dmem_rdata) + 8'h01) >= 8'h80);
          state_q                 <= S_Q4;
        end
        S_Q4: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // architectural registers
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      instr_q    <= `RST_WORD;
      wreg_q     <= `RST_BYTE;
      bsr_q      <= `RST_BANK;
      ext_q      <= 1'b0;
      flags_q    <= `RST_FLAGS;
      prod_hi_q  <= `RST_BYTE;
      prod_lo_q  <= `RST_BYTE;
      fsr2_q     <= `RST_ADDR;
      mem_addr_q <= `RST_ADDR;
      ptr_q      <= `STK_EMPTY;
      unsup_q    <= 1'b0;
      under_q    <= 1'b0;
      over_q     <= 1'b0;
    end else begin
      if (state_q == S_Q4) begin
        if (is_mull_q || is_mulf_q) begin
          prod_hi_q <= prod_calc_q[15:8];
          prod_lo_q <= prod_calc_q[7:0];
        end
        if (is_neg_q) begin
          flags_q <= neg_flags_q;
        end
        if (is_pop_q) begin
          if (ptr_q != `STK_EMPTY) begin
            ptr_q <= ptr_q - `STK_ONE;
          end else begin
            under_q <= 1'b1;
          end
        end
        if (!(is_mull_q || is_mulf_q || is_neg_q || is_pop_q || d_idle)) begin
          unsup_q <= 1'b1;
        end
      end
      if (apb_wr && !busy) begin
        case (PADDR)
          `ADDR_INSTR:    instr_q    <= PWDATA[15:0];
          `ADDR_WREG:     wreg_q     <= PWDATA[7:0];
          `ADDR_BANK_SEL: bsr_q      <= PWDATA[3:0];
          `ADDR_CTRL:     ext_q      <= PWDATA[`CTRL_EXT_BIT];
          `ADDR_STATUS:   flags_q    <= PWDATA[4:0];
          `ADDR_FSR2:     fsr2_q     <= PWDATA[11:0];
          `ADDR_MEM_ADDR: mem_addr_q <= PWDATA[11:0];
          `ADDR_PROD: begin
            prod_hi_q <= PWDATA[15:8];
            prod_lo_q <= PWDATA[7:0];
          end
          `ADDR_STACK: begin
            if (ptr_q != `STK_FULL) begin
              ptr_q <= ptr_q + `STK_ONE;
            end else begin
              over_q <= 1'b1;
            end
          end
          `ADDR_EXEC_STAT: begin
            if (PWDATA[`ES_UNSUP]) begin
              unsup_q <= 1'b0;
            end
            if (PWDATA[`ES_UNDER]) begin
              under_q <= 1'b0;
            end
            if (PWDATA[`ES_OVER]) begin
              over_q <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // apb read mux
  always @* begin
    rdata_d = `RST_DATA;
    err_d   = 1'b0;
    case (PADDR)
      `ADDR_INSTR:     rdata_d[15:0] = instr_q;
      `ADDR_WREG:      rdata_d[7:0]  = wreg_q;
      `ADDR_BANK_SEL:  rdata_d[3:0]  = bsr_q;
      `ADDR_CTRL:      rdata_d[`CTRL_EXT_BIT] = ext_q;
      `ADDR_STATUS:    rdata_d[4:0]  = flags_q;
      `ADDR_PROD:      rdata_d[15:0] = {prod_hi_q, prod_lo_q};
      `ADDR_FSR2:      rdata_d[11:0] = fsr2_q;
      `ADDR_MEM_ADDR:  rdata_d[11:0] = mem_addr_q;
      `ADDR_MEM_DATA:  rdata_d[7:0]  = dmem_rdata;
      `ADDR_STACK: begin
        if (ptr_q != `STK_EMPTY) begin
          rdata_d[`STK_DW-1:0] = stk_rdata;
        end
      end
      `ADDR_EXEC_STAT: begin
        rdata_d[`ES_BUSY]  = busy;
        rdata_d[`ES_UNSUP] = unsup_q;
        rdata_d[`ES_UNDER] = under_q;
        rdata_d[`ES_OVER]  = over_q;
        rdata_d[`ES_PTR_MSB:`ES_PTR_LSB] = ptr_q;
      end
      default: err_d = 1'b1;
    endcase
  end

  // ==========================================================
  // apb handshake, registered answer
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= `RST_DATA;
      PSLVERR <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      // one more cycle after execution: memory and stack read data settle
      busy_q <= busy;
      PREADY <= PSEL & PENABLE & ~PREADY & ~busy & ~busy_q;
      if (PSEL & PENABLE & ~PREADY & ~busy & ~busy_q) begin
        PRDATA  <= PWRITE ? `RST_DATA : rdata_d;
        PSLVERR <= err_d;
      end else begin
        PRDATA  <= `RST_DATA;
        PSLVERR <= 1'b0;
      end
    end
  end

endmodule // multiply_negate_pop_exec

`default_nettype wire

/* tb/multiply_negate_pop_exec_sva.sv */
`include "exec_core_regs.vh"
`default_nettype none

// ==========================================================
// apb port checker
module multiply_negate_pop_exec_sva (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  wire instr_taken = PSEL && PENABLE && PREADY && PWRITE && (PADDR == `ADDR_INSTR);

  // ==========================================================
  // assertions
  rdy_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  rdy_needs_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access phase");
  rdy_one_wait_a: assert property ($rose(PENABLE) && PSEL |-> !PREADY)
    else $error("ready without wait cycle");
  rdy_bounded_a: assert property (PSEL && PENABLE && !PREADY |-> ##[1:6] PREADY)
    else $error("ready never came");
  exec_holds_bus_a: assert property (instr_taken |=> !PREADY [*4])
    else $error("transfer answered during execution");
  err_with_rdy_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  unmapped_err_a: assert property (PREADY && PADDR[1:0] == 2'h0
      |-> PSLVERR == (PADDR > `ADDR_EXEC_STAT))
    else $error("error flag wrong for address");
  rdata_idle_zero_a: assert property (!PREADY || PSLVERR |-> PRDATA == 32'h00000000)
    else $error("read data not zero");
  prod_width_a: assert property (PREADY && !PWRITE && PADDR == `ADDR_PROD
      |-> PRDATA[31:16] == 16'h0000)
    else $error("product wider than 16 bits");

  // ==========================================================
  // covers
  instr_write_c: cover property (instr_taken);
  slverr_c: cover property (PSLVERR);
  prod_read_c: cover property (PREADY && !PWRITE && PADDR == `ADDR_PROD);
endmodule // multiply_negate_pop_exec_sva

`default_nettype wire

/* tb/multiply_negate_pop_exec_tb.sv */
`include "exec_core_regs.vh"
`default_nettype none

module multiply_negate_pop_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] r;
  logic        e;
  logic [7:0]  v;
  logic [7:0]  nv;
  logic [7:0]  vals [4] = '{8'h3A, 8'h00, 8'h80, 8'h10};

  multiply_negate_pop_exec uut (
    .CLK     (clk),
    .ARST_N  (arst_n),
    .PSEL    (psel),
    .PENABLE (penable),
    .PWRITE  (pwrite),
    .PADDR   (paddr),
    .PWDATA  (pwdata),
    .PRDATA  (prdata),
    .PREADY  (pready),
    .PSLVERR (pslverr)
  );

  always #5 clk = ~clk;

  // ==========================================================
  // tasks
  task automatic complete_run();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(r, exp);
  endtask

  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(`ADDR_MEM_ADDR, {20'h00000, a});
    wr(`ADDR_MEM_DATA, {24'h000000, d});
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rc(`ADDR_PROD, 32'h00000000);
    wr(`ADDR_WREG, 32'h000000E2);
    wr(`ADDR_STATUS, 32'h0000000A);
    wr(`ADDR_INSTR, 32'h00000DC4);
    rc(`ADDR_PROD, 32'h0000AD08);
    rc(`ADDR_WREG, 32'h000000E2);
    wr(`ADDR_INSTR, 32'h00000D00);
    rc(`ADDR_PROD, 32'h00000000);
    rc(`ADDR_STATUS, 32'h0000000A);
    wr(`ADDR_WREG, 32'h000000FF);
    wr(`ADDR_INSTR, 32'h00000DFF);
    rc(`ADDR_PROD, 32'h0000FE01);
    wr(`ADDR_WREG, 32'h000000C4);
    wr(`ADDR_BANK_SEL, 32'h00000001);
    mw(12'h1B5, 8'hB5);
    wr(`ADDR_INSTR, 32'h000003B5);
    rc(`ADDR_PROD, 32'h00008A94);
    rc(`ADDR_MEM_DATA, 32'h000000B5);
    rc(`ADDR_WREG, 32'h000000C4);
    mw(12'hF60, 8'h10);
    wr(`ADDR_INSTR, 32'h00000260);
    rc(`ADDR_PROD, 32'h00000C40);
    mw(12'h005, 8'h03);
    wr(`ADDR_INSTR, 32'h00000205);
    rc(`ADDR_PROD, 32'h0000024C);
    wr(`ADDR_CTRL, 32'h00000001);
    wr(`ADDR_FSR2, 32'h00000300);
    mw(12'h305, 8'h02);
    wr(`ADDR_INSTR, 32'h00000205);
    rc(`ADDR_PROD, 32'h00000188);
    rc(`ADDR_STATUS, 32'h0000000A);
    for (int i = 0; i < 4; i++) begin
      v = vals[i];
      nv = 8'h00 - v;
      mw(12'h120, v);
      wr(`ADDR_STATUS, 32'h00000000);
      wr(`ADDR_INSTR, 32'h00006D20);
      rc(`ADDR_MEM_DATA, {24'h000000, nv});
      rc(`ADDR_STATUS, {27'h0, nv[7], v == 8'h80, v == 8'h00,
        v[3:0] == 4'h0, v == 8'h00});
    end
    wr(`ADDR_STACK, 32'h00012345);
    wr(`ADDR_STACK, 32'h00054321);
    wr(`ADDR_INSTR, 32'h00000006);
    rc(`ADDR_STACK, 32'h00012345);
    rc(`ADDR_EXEC_STAT, 32'h00000100);
    wr(`ADDR_INSTR, 32'h00000006);
    wr(`ADDR_INSTR, 32'h00000006);
    rc(`ADDR_STACK, 32'h00000000);
    rc(`ADDR_EXEC_STAT, 32'h00000004);
    wr(`ADDR_EXEC_STAT, 32'h0000000E);
    wr(`ADDR_INSTR, 32'h00000000);
    wr(`ADDR_INSTR, 32'h0000F123);
    rc(`ADDR_EXEC_STAT, 32'h00000000);
    rc(`ADDR_PROD, 32'h00000188);
    rc(`ADDR_WREG, 32'h000000C4);
    wr(`ADDR_INSTR, 32'h00000E55);
    rc(`ADDR_EXEC_STAT, 32'h00000002);
    rc(`ADDR_WREG, 32'h000000C4);
    apb(1'b0, 12'h100, 32'h00000000);
    chk(r, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    complete_run();
  end
endmodule // multiply_negate_pop_exec_tb

bind multiply_negate_pop_exec multiply_negate_pop_exec_sva chk_i (
  .CLK     (CLK),
  .ARST_N  (ARST_N),
  .PSEL    (PSEL),
  .PENABLE (PENABLE),
  .PWRITE  (PWRITE),
  .PADDR   (PADDR),
  .PWDATA  (PWDATA),
  .PRDATA  (PRDATA),
  .PREADY  (PREADY),
  .PSLVERR (PSLVERR)
);

`default_nettype wire
